// ===== src/csr_pkg.sv
// constants for the clock synthesizer configuration bank
// assumes a byte-wide register port driven by the serial control front end
package csr_pkg;
	localparam logic [7:0] ADR_OUTPUT_CONTROL = 8'h02;
	localparam logic [7:0] ADR_CONFIG_ONE = 8'h03;
	localparam logic [7:0] ADR_CONFIG_TWO = 8'h04;
	localparam logic [7:0] ADR_GLOBAL_CONFIG = 8'h05;
	localparam logic [7:0] ADR_RATIO_BASE = 8'h06;
	localparam logic [7:0] ADR_RATIO_LAST = 8'h15;
	localparam int RATIO_COUNT = 4;
	localparam int RATIO_BYTES = 4;
	// output control fields
	localparam int BIT_UNLOCK = 7;
	localparam int BIT_AUX_HIZ = 1;
	localparam int BIT_MAIN_HIZ = 0;
	// config one fields
	localparam int SHIFT_HI = 7;
	localparam int SHIFT_LO = 5;
	localparam int SIDX_HI = 4;
	localparam int SIDX_LO = 3;
	localparam int ASRC_HI = 2;
	localparam int ASRC_LO = 1;
	localparam int BIT_EN_A = 0;
	// config two fields
	localparam int DIDX_HI = 2;
	localparam int DIDX_LO = 1;
	localparam int BIT_FRAC = 0;
	// global config fields
	localparam int BIT_FREEZE = 3;
	localparam int BIT_EN_B = 0;
	// writable masks; reserved bits read zero
	localparam logic [7:0] MASK_OUTPUT_CONTROL = 8'h03;
	localparam logic [7:0] MASK_CONFIG_TWO = 8'h07;
	localparam logic [7:0] MASK_GLOBAL_CONFIG = 8'h09;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] RESET_RATIO = 32'h0000_0000;
	// aux source codes
	localparam logic [1:0] ASRC_REF = 2'h0;
	localparam logic [1:0] ASRC_SYNC = 2'h1;
	localparam logic [1:0] ASRC_MAIN = 2'h2;
	localparam logic [1:0] ASRC_LOCK = 2'h3;
	localparam int SHIFT_RIGHT_BIT = 2;
endpackage

// ===== src/csr_ratio_mem.sv
// four 32-bit user ratios, written a byte at a time, read out registered
// assumes writes arrive from the register port on the same clock
`timescale 1ns/1ps
module csr_ratio_mem (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [1:0] wr_ratio,
	input wire logic [1:0] wr_byte,
	input wire logic [7:0] wr_data,
	input wire logic [1:0] rd_ratio,
	input wire logic [1:0] rd_byte,
	output logic [7:0] rd_data_ff,
	input wire logic [1:0] sel_static,
	input wire logic [1:0] sel_dynamic,
	output logic [31:0] static_ratio_ff,
	output logic [31:0] dynamic_ratio_ff
);
	typedef struct packed {
		logic [csr_pkg::RATIO_COUNT-1:0][31:0] word;
		logic [7:0] rd;
		logic [31:0] st;
		logic [31:0] dy;
		logic [csr_pkg::RATIO_COUNT-1:0] pend;
	} csr_mem_t;
	csr_mem_t cur_ff, nxt_ff;
	logic [1:0] last_byte;

	// index of the least significant byte lane of a ratio
	assign last_byte = 2'(csr_pkg::RATIO_BYTES - 1);

	// byte lane 0 is the most significant byte of the ratio
	always_comb begin
		nxt_ff = cur_ff;
		if (wr_en) begin
			nxt_ff.word[wr_ratio][8*(last_byte-wr_byte) +: 8] = wr_data;
			// a ratio stays incomplete until its last byte lands
			nxt_ff.pend[wr_ratio] = wr_byte != last_byte;
		end
		nxt_ff.rd = cur_ff.word[rd_ratio][8*(last_byte-rd_byte) +: 8];
		// whole words only; a half written ratio keeps the old word out
		if (!cur_ff.pend[sel_static]) begin
			nxt_ff.st = cur_ff.word[sel_static];
		end
		if (!cur_ff.pend[sel_dynamic]) begin
			nxt_ff.dy = cur_ff.word[sel_dynamic];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign rd_data_ff = cur_ff.rd;
	assign static_ratio_ff = cur_ff.st;
	assign dynamic_ratio_ff = cur_ff.dy;
endmodule

// ===== src/csr_ratio_apply.sv
// applies the shift select to a ratio and picks the synthesizer source
// assumes inputs are whole 32-bit ratios from the ratio store
`timescale 1ns/1ps
module csr_ratio_apply (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [2:0] ratio_shift_select,
	input wire logic fractional_source_select,
	input wire logic [31:0] static_ratio,
	input wire logic [31:0] dynamic_ratio,
	output logic [31:0] effective_ratio_ff,
	output logic [31:0] synth_ratio_ff
);
	typedef struct packed {
		logic [31:0] eff;
		logic [31:0] syn;
	} csr_apply_t;
	csr_apply_t cur_ff, nxt_ff;
	logic [1:0] amt;

	// left by 0..3, right by 1..4
	always_comb begin
		nxt_ff = cur_ff;
		amt = ratio_shift_select[1:0];
		if (ratio_shift_select[csr_pkg::SHIFT_RIGHT_BIT]) begin
			nxt_ff.eff = (static_ratio >> amt) >> 1;
		end else begin
			nxt_ff.eff = static_ratio << amt;
		end
		nxt_ff.syn = fractional_source_select ? dynamic_ratio
			: cur_ff.eff;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign effective_ratio_ff = cur_ff.eff;
	assign synth_ratio_ff = cur_ff.syn;
endmodule

// ===== src/csr_config_regs.sv
// configuration register bank of a fractional-N clock synthesizer
// assumes a byte register port from the serial front end on clk_sys,
// with asynchronous clock and lock inputs from the analog side
`timescale 1ns/1ps
module csr_config_regs (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic pll_unlocked,
	input wire logic timing_reference_clock,
	input wire logic sync_clock_in,
	input wire logic synth_clock,
	input wire logic lock_pin_style,
	output logic main_clk_out,
	output logic main_clk_oe,
	output logic aux_out,
	output logic aux_oe,
	output logic config_enabled,
	output logic [31:0] effective_ratio,
	output logic [31:0] synth_ratio
);
	typedef struct packed {
		logic [7:0] out_sh;
		logic [7:0] cfg1_sh;
		logic [7:0] cfg2_sh;
		logic [7:0] out_act;
		logic [7:0] cfg1_act;
		logic [7:0] cfg2_act;
		logic [7:0] glob;
		logic [3:0] ref_s;
		logic [3:0] sync_s;
		logic [3:0] syn_s;
		logic [1:0] unl_s;
		logic [1:0] sty_s;
		logic rvalid;
		logic rd_ratio;
		logic [7:0] rdata;
		logic aux;
		logic aux_en;
		logic main;
		logic main_en;
	} csr_state_t;
	csr_state_t cur_ff, nxt_ff;

	logic in_ratio;
	logic [7:0] roff;
	logic [7:0] rd_roff;
	logic [31:0] st_ratio;
	logic [31:0] dy_ratio;
	logic [7:0] mem_rdata;
	logic freeze;
	logic unl, sty, ref_c, sync_c, syn_c;

	// ratio window decode, ratio n at base plus four n
	assign in_ratio = reg_addr >= csr_pkg::ADR_RATIO_BASE
		&& reg_addr <= csr_pkg::ADR_RATIO_LAST;
	assign roff = reg_addr - csr_pkg::ADR_RATIO_BASE;
	assign freeze = cur_ff.glob[csr_pkg::BIT_FREEZE];
	// synchronised inputs, second stage only
	assign ref_c = cur_ff.ref_s[1];
	assign sync_c = cur_ff.sync_s[1];
	assign syn_c = cur_ff.syn_s[1];
	assign unl = cur_ff.unl_s[1];
	assign sty = cur_ff.sty_s[1];

	// byte-wide ratio store with registered read
	csr_ratio_mem u_mem (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(reg_wr && in_ratio),
		.wr_ratio(roff[3:2]),
		.wr_byte(roff[1:0]),
		.wr_data(reg_wdata),
		.rd_ratio(rd_roff[3:2]),
		.rd_byte(rd_roff[1:0]),
		.rd_data_ff(mem_rdata),
		.sel_static(cur_ff.cfg1_act[csr_pkg::SIDX_HI:csr_pkg::SIDX_LO]),
		.sel_dynamic(cur_ff.cfg2_act[csr_pkg::DIDX_HI:csr_pkg::DIDX_LO]),
		.static_ratio_ff(st_ratio),
		.dynamic_ratio_ff(dy_ratio)
	);
	assign rd_roff = roff;

	// shift select and fractional source
	csr_ratio_apply u_apply (
		.clk_sys(clk_sys),
		.rst(rst),
		.ratio_shift_select(
			cur_ff.cfg1_act[csr_pkg::SHIFT_HI:csr_pkg::SHIFT_LO]),
		.fractional_source_select(cur_ff.cfg2_act[csr_pkg::BIT_FRAC]),
		.static_ratio(st_ratio),
		.dynamic_ratio(dy_ratio),
		.effective_ratio_ff(effective_ratio),
		.synth_ratio_ff(synth_ratio)
	);

	// register writes, freeze shadowing, reads and pin drive
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.ref_s = {cur_ff.ref_s[2:0], timing_reference_clock};
		nxt_ff.sync_s = {cur_ff.sync_s[2:0], sync_clock_in};
		nxt_ff.syn_s = {cur_ff.syn_s[2:0], synth_clock};
		nxt_ff.unl_s = {cur_ff.unl_s[0], pll_unlocked};
		nxt_ff.sty_s = {cur_ff.sty_s[0], lock_pin_style};
		if (reg_wr) begin
			case (reg_addr)
				csr_pkg::ADR_OUTPUT_CONTROL: begin
					nxt_ff.out_sh = reg_wdata
						& csr_pkg::MASK_OUTPUT_CONTROL;
				end
				csr_pkg::ADR_CONFIG_ONE: begin
					nxt_ff.cfg1_sh = reg_wdata;
				end
				csr_pkg::ADR_CONFIG_TWO: begin
					nxt_ff.cfg2_sh = reg_wdata
						& csr_pkg::MASK_CONFIG_TWO;
				end
				csr_pkg::ADR_GLOBAL_CONFIG: begin
					nxt_ff.glob = reg_wdata
						& csr_pkg::MASK_GLOBAL_CONFIG;
				end
				default: begin
				end
			endcase
		end
		// shadows pass to the active copy whenever freeze is clear
		if (!nxt_ff.glob[csr_pkg::BIT_FREEZE]) begin
			nxt_ff.out_act = nxt_ff.out_sh;
			nxt_ff.cfg1_act = nxt_ff.cfg1_sh;
			nxt_ff.cfg2_act = nxt_ff.cfg2_sh;
		end
		// read answers one cycle after the strobe
		nxt_ff.rvalid = reg_rd;
		nxt_ff.rd_ratio = reg_rd && in_ratio;
		nxt_ff.rdata = csr_pkg::RESET_BYTE;
		case (reg_addr)
			csr_pkg::ADR_OUTPUT_CONTROL: begin
				nxt_ff.rdata = cur_ff.out_sh;
				nxt_ff.rdata[csr_pkg::BIT_UNLOCK] = unl;
			end
			csr_pkg::ADR_CONFIG_ONE: nxt_ff.rdata = cur_ff.cfg1_sh;
			csr_pkg::ADR_CONFIG_TWO: nxt_ff.rdata = cur_ff.cfg2_sh;
			csr_pkg::ADR_GLOBAL_CONFIG: nxt_ff.rdata = cur_ff.glob;
			default: nxt_ff.rdata = csr_pkg::RESET_BYTE;
		endcase
		// main clock driver
		nxt_ff.main = syn_c;
		nxt_ff.main_en = !cur_ff.out_act[csr_pkg::BIT_MAIN_HIZ];
		// aux source and driver
		nxt_ff.aux_en = !cur_ff.out_act[csr_pkg::BIT_AUX_HIZ];
		case (cur_ff.cfg1_act[csr_pkg::ASRC_HI:csr_pkg::ASRC_LO])
			csr_pkg::ASRC_REF: nxt_ff.aux = ref_c;
			csr_pkg::ASRC_SYNC: nxt_ff.aux = sync_c;
			csr_pkg::ASRC_MAIN: nxt_ff.aux = syn_c;
			csr_pkg::ASRC_LOCK: begin
				if (sty) begin
					// open drain, pulls low while unlocked
					nxt_ff.aux = 1'b0;
					nxt_ff.aux_en = nxt_ff.aux_en && unl;
				end else begin
					nxt_ff.aux = unl;
				end
			end
			default: nxt_ff.aux = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// both enables needed, either order accepted
	assign config_enabled = cur_ff.cfg1_act[csr_pkg::BIT_EN_A]
		&& cur_ff.glob[csr_pkg::BIT_EN_B];
	assign reg_rdata = cur_ff.rd_ratio ? mem_rdata : cur_ff.rdata;
	assign reg_rvalid = cur_ff.rvalid;
	// drivers held off until the bank is enabled
	assign main_clk_out = cur_ff.main;
	assign main_clk_oe = cur_ff.main_en && config_enabled;
	assign aux_out = cur_ff.aux;
	assign aux_oe = cur_ff.aux_en && config_enabled;
endmodule

// ===== bench/csr_config_regs_properties.sv
// checker for the configuration bank register port and pin gating
// assumes it is bound to csr_config_regs and sees only its ports
`timescale 1ns/1ps
module csr_config_regs_properties (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic pll_unlocked,
	input wire logic main_clk_oe,
	input wire logic config_enabled
);
	logic [3:0] rst_hist_ff;
	logic freeze_ff;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// host-side copy of the freeze bit, taken from writes to 05h
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			freeze_ff <= 1'b0;
		end else if (reg_wr && reg_addr == 8'h05) begin
			freeze_ff <= reg_wdata[3];
		end
	end
	// recent reset history, so the lock synchroniser has settled
	always_ff @(posedge clk_sys) begin
		rst_hist_ff <= {rst_hist_ff[2:0], rst};
	end
	rd_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read got no answer");
	answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("answer without a read");
	unmapped_zero_a: assert property (reg_rd && (reg_addr < 8'h02 ||
		reg_addr > 8'h15) |=> reg_rdata == 8'h00) else $error("unmapped read");
	cfg_two_rsvd_a: assert property (reg_rd && reg_addr == 8'h04
		|=> reg_rdata[7:3] == 5'h00) else $error("reserved bits set");
	global_rsvd_a: assert property (reg_rd && reg_addr == 8'h05
		|=> (reg_rdata & 8'hf6) == 8'h00) else $error("reserved bits set");
	unlock_read_a: assert property (reg_rd && reg_addr == 8'h02 &&
		rst_hist_ff == 4'h0 && $stable(pll_unlocked) &&
		pll_unlocked == $past(pll_unlocked, 2) &&
		pll_unlocked == $past(pll_unlocked, 3)
		|=> reg_rdata[7] == $past(pll_unlocked, 2))
		else $error("lock state read wrong");
	main_oe_gate_a: assert property (reg_wr && reg_addr == 8'h02 &&
		reg_wdata[0] && !freeze_ff |=> ##1 !main_clk_oe)
		else $error("main driver still on after disable");
	en_b_clear_a: assert property (reg_wr && reg_addr == 8'h05 &&
		!reg_wdata[0] |=> !config_enabled) else $error("still enabled");
endmodule

// ===== bench/csr_config_regs_tb.sv
// self-checking bench for the synthesizer configuration bank
// assumes the bank alone, every input driven from here
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module csr_config_regs_tb;
	logic clk_sys, rst, reg_wr, reg_rd, reg_rvalid, pll_unlocked;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic timing_reference_clock, sync_clock_in, synth_clock, lock_pin_style;
	logic main_clk_out, main_clk_oe, aux_out, aux_oe, config_enabled;
	logic [31:0] effective_ratio, synth_ratio, w;
	int error_cnt, samples_checked;
	localparam logic [31:0] RV [4] = '{32'h8123_4567, 32'h0f1e_2d3c,
		32'h7654_3210, 32'hc0de_0001};
	csr_config_regs csr_config_regs_inst (.clk_sys(clk_sys), .rst(rst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.pll_unlocked(pll_unlocked),
		.timing_reference_clock(timing_reference_clock),
		.sync_clock_in(sync_clock_in), .synth_clock(synth_clock),
		.lock_pin_style(lock_pin_style), .main_clk_out(main_clk_out),
		.main_clk_oe(main_clk_oe), .aux_out(aux_out), .aux_oe(aux_oe),
		.config_enabled(config_enabled), .effective_ratio(effective_ratio),
		.synth_ratio(synth_ratio));
	// 100 ns clock
	initial begin
		clk_sys = 0;
		forever #50 clk_sys = ~clk_sys;
	end
	// wait n edges, then step past them
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		wt(1);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = v;
		wt(1);
		reg_wr = 0;
	endtask
	// one-cycle read strobe, answer taken one edge later
	task automatic rd(input logic [7:0] a);
		wt(1);
		reg_rd = 1;
		reg_addr = a;
		wt(1);
		reg_rd = 0;
		`CHK("rvalid", 1'b1, reg_rvalid)
		d = reg_rdata;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hang guard, about fifteen times the expected run
	initial begin
		#500000;
		error_cnt++;
		wrap_up();
	end
	// main sequence
	initial begin
		{rst, timing_reference_clock, synth_clock} = 3'h7;
		{reg_wr, reg_rd, pll_unlocked, sync_clock_in} = 4'h0;
		{reg_addr, reg_wdata, lock_pin_style} = 17'h0_0000;
		wt(2);
		rst = 0;
		for (int a = 2; a < 6; a++) begin
			rd(8'(a));
			`CHK("reset", 8'h00, d)
		end
		$display("test reset done");
		wr(8'h05, 8'h01); // reserved bits left zero
		wt(3);
		`CHK("enabled", 1'b0, config_enabled)
		wr(8'h03, 8'h01);
		wt(3);
		`CHK("enabled", 1'b1, config_enabled)
		`CHK("main oe", 1'b1, main_clk_oe)
		wr(8'h02, 8'h01);
		wt(3);
		`CHK("main oe", 1'b0, main_clk_oe)
		`CHK("aux oe", 1'b1, aux_oe)
		wr(8'h02, 8'h02);
		wt(3);
		`CHK("main oe", 1'b1, main_clk_oe)
		`CHK("aux oe", 1'b0, aux_oe)
		wr(8'h02, 8'h00);
		`CHK("main out", 1'b1, main_clk_out)
		synth_clock = 0;
		wt(4);
		`CHK("main out", 1'b0, main_clk_out)
		synth_clock = 1;
		$display("test drivers done");
		for (int s = 0; s < 3; s++) begin
			wr(8'h03, {5'h00, s[1:0], 1'b1});
			wt(8);
			`CHK("aux out", s != 1, aux_out)
		end
		pll_unlocked = 1;
		wr(8'h03, 8'h07);
		wt(8);
		`CHK("aux out", 1'b1, aux_out)
		rd(8'h02);
		`CHK("unlock", 1'b1, d[7])
		lock_pin_style = 1;
		wt(8);
		`CHK("aux drain", 2'b01, {aux_out, aux_oe})
		pll_unlocked = 0;
		wt(8);
		`CHK("aux oe", 1'b0, aux_oe)
		lock_pin_style = 0;
		$display("test aux done");
		for (int n = 0; n < 16; n++)
			wr(8'h06 + 8'(n), RV[n/4][31 - 8 * (n % 4) -: 8]);
		for (int n = 0; n < 16; n++) begin
			rd(8'h06 + 8'(n));
			`CHK("ratio byte", RV[n/4][31 - 8 * (n % 4) -: 8], d)
		end
		for (int n = 0; n < 4; n++) begin
			wr(8'h03, {3'h0, n[1:0], 3'h1});
			wt(6);
			`CHK("eff", RV[n], effective_ratio)
			`CHK("synth", RV[n], synth_ratio)
		end
		for (int s = 0; s < 8; s++) begin
			wr(8'h03, {s[2:0], 5'h09});
			wt(6);
			w = (s < 4) ? RV[1] << s : RV[1] >> (s - 3);
			`CHK("shifted", w, effective_ratio)
		end
		wr(8'h03, 8'h01);
		for (int n = 0; n < 4; n++) begin
			wr(8'h04, {5'h00, n[1:0], 1'b1});
			wt(6);
			`CHK("dynamic", RV[n], synth_ratio)
		end
		$display("test ratios done");
		wr(8'h05, 8'h09);
		wr(8'h02, 8'h03);
		wt(3);
		`CHK("frozen oe", 1'b1, main_clk_oe)
		rd(8'h02);
		`CHK("shadow", 2'h3, d[1:0])
		wr(8'h05, 8'h01);
		wt(3);
		`CHK("thawed oe", 2'h0, {main_clk_oe, aux_oe})
		$display("test freeze done");
		// selected ratio rewritten byte by byte: old word until the last
		wr(8'h06, 8'h55);
		wt(6);
		`CHK("partial", RV[0], effective_ratio)
		for (int n = 1; n < 4; n++)
			wr(8'h06 + 8'(n), RV[0][31 - 8 * n -: 8]);
		wt(6);
		`CHK("whole", {8'h55, RV[0][23:0]}, effective_ratio)
		wr(8'h04, 8'hff);
		rd(8'h04);
		`CHK("reserved", 8'h07, d)
		wr(8'h16, 8'hff);
		rd(8'h16);
		`CHK("unmapped", 8'h00, d)
		wr(8'h05, 8'h00);
		wt(3);
		`CHK("enabled", 1'b0, config_enabled)
		$display("test map done");
		wrap_up();
	end
endmodule
bind csr_config_regs csr_config_regs_properties csr_config_regs_properties_inst (
	.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .pll_unlocked(pll_unlocked),
	.main_clk_oe(main_clk_oe), .config_enabled(config_enabled));
